// ==== rtl/nvm_page_programmer.sv ====
// paged program memory with two-wire programming link and run-time block writes
// Functional notes
// - memory space is 256-byte pages, each eight 32-byte blocks
// - address bits 15:8 page, 7:5 block, 4:0 byte in block
// - each commit writes one whole 32-byte block, taking about 2.5 ms
// - a 128-byte bench answers only in-page offsets 128 to 255
// - programming mode only when the programming-voltage pin is high at reset
// - programming commands and data travel over the two-wire link as slave
// - one identical protocol for standalone and in-system programming
// - software may also write blocks at run time, outside programming mode
// - while locked, reads over the programming link return no code; a reset clears the lock
// - protected flash and EEPROM pages refuse every write
// - fetch allowed from any populated address, any bench
// - slave address 1010000 write, then mode code 00000000, both acknowledged
// - block advance counts modulo 8, page increments on wrap
// - programming mode starts with pointer at page 48, block 3, byte 0
`timescale 1ns/100ps
module nvm_page_programmer
    import nvm_prog_pkg::*;
#(
    parameter logic [63:0] FLASH_MAP    = 64'h0000_0000_0000_FFFF,
    parameter logic [63:0] RAM_MAP      = 64'h0000_0001_0000_0000,
    parameter logic [63:0] EEPROM_MAP   = 64'h0000_0000_0003_0000,
    parameter logic [63:0] HALF_MAP     = 64'h0000_0000_0000_0000,
    parameter logic [63:0] OPTION_MAP   = 64'h0001_0000_0000_0000,
    parameter int          WRITE_CYCLES = BLOCK_WRITE_CYCLES,
    parameter int          ERASE_CYCLES = GLOBAL_ERASE_CYCLES
)(
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    input  wire logic         i_vpp_high,
    input  wire logic         i_scl,
    output logic              o_scl_o,
    output logic              o_scl_oe,
    input  wire logic         i_sda,
    output logic              o_sda_o,
    output logic              o_sda_oe,
    input  wire logic [63:0]  i_page_protect,
    input  wire logic         i_self_req,
    input  wire nvm_addr_type i_self_addr,
    input  wire logic [255:0] i_self_data,
    output logic              o_self_busy,
    input  wire nvm_addr_type i_fetch_addr,
    output logic [7:0]        o_fetch_data,
    output logic              o_prog_mode,
    output logic              o_locked
);
    if (WRITE_CYCLES < 1 || ERASE_CYCLES < MEM_BLOCKS + 1)
    begin
        $error("nvm_page_programmer: commit or erase count too small");
    end

    logic                rst_meta;
    logic                rst_sync_b;
    logic                scl_meta;
    logic                scl_s;
    logic                scl_d;
    logic                sda_meta;
    logic                sda_s;
    logic                sda_d;
    logic                vpp_meta;
    logic                vpp_s;
    logic [1:0]          strap_wait;
    logic                strap_done;
    logic                prog_mode;
    link_state_type      state;
    logic [3:0]          bit_cnt;
    logic [7:0]          shreg;
    logic                was_addr;
    logic                rw;
    logic                ack_next;
    logic                stretch;
    logic                mode_ok;
    logic                cmd_wait;
    logic [7:0]          cmd;
    logic [4:0]          arg_cnt;
    nvm_addr_type        ptr;
    logic [7:0]          tx_byte;
    logic                prot_err;
    logic                absent_err;
    logic                locked;
    logic                busy;
    logic                busy_erase;
    logic [31:0]         busy_cnt;
    logic [9:0]          erase_idx;
    logic [7:0]          cm_page;
    logic [2:0]          cm_block;
    logic                cm_fast;
    logic [255:0]        wbuf;
    logic [7:0]          mem [0:MEM_PAGES*PAGE_BYTES-1];

    // two-flop capture of reset release and of the clock, data and vpp pins
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_meta   <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_meta   <= 1'b1;
            rst_sync_b <= rst_meta;
        end
    end

    always_ff @(posedge i_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            {scl_meta, scl_s, scl_d} <= 3'h7;
            {sda_meta, sda_s, sda_d} <= 3'h7;
            {vpp_meta, vpp_s}        <= 2'h0;
        end
        else
        begin
            {scl_meta, scl_s, scl_d} <= {i_scl, scl_meta, scl_s};
            {sda_meta, sda_s, sda_d} <= {i_sda, sda_meta, sda_s};
            {vpp_meta, vpp_s}        <= {i_vpp_high, vpp_meta};
        end
    end

    // strap is read once the synchronisers have filled after release
    always_ff @(posedge i_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            strap_wait <= 2'h0;
            strap_done <= 1'b0;
            prog_mode  <= 1'b0;
        end
        else if (!strap_done)
        begin
            strap_wait <= strap_wait + 2'h1;
            if (strap_wait == 2'h2)
            begin
                strap_done <= 1'b1;
                prog_mode  <= vpp_s;
            end
        end
    end

    // page routing: absent pages and the lower half of 128-byte benches
    function automatic logic present(input logic [7:0] pg, input logic ofs_hi);
        logic [63:0] any_map;
        any_map = FLASH_MAP | RAM_MAP | EEPROM_MAP | OPTION_MAP;
        present = (pg < 8'(MEM_PAGES)) && any_map[pg[5:0]]
                  && !(HALF_MAP[pg[5:0]] && !ofs_hi);
    endfunction

    // protect vector is an argument so the wire re-evaluates when it changes
    function automatic logic guarded(input logic [7:0] pg, input logic [63:0] pv);
        guarded = (FLASH_MAP[pg[5:0]] | EEPROM_MAP[pg[5:0]]) && pv[pg[5:0]];
    endfunction

    wire        scl_rise  = scl_s && !scl_d;
    wire        scl_fall  = !scl_s && scl_d;
    wire        start_det = scl_s && scl_d && sda_d && !sda_s;
    wire        stop_det  = scl_s && scl_d && !sda_d && sda_s;
    wire [7:0]  byte_val  = {shreg[6:0], sda_s};
    wire        byte_done = scl_rise && bit_cnt == 4'h7 && (state == L_ADDR || state == L_RX);
    wire        rx_byte   = byte_done && state == L_RX;
    wire        addr_ok   = byte_val[7:1] == SLAVE_ADDR && prog_mode;
    wire        data_ok   = mode_ok || byte_val == MODE_CODE;
    wire [13:0] ptr_idx   = {ptr.page[5:0], ptr.block, ptr.offset};
    wire [7:0]  rd_byte   = present(ptr.page, ptr.block[2]) ? mem[ptr_idx] : 8'h00;
    wire [7:0]  status    = {4'h0, busy, absent_err, prot_err, locked};
    wire        cmd_write = cmd == CMD_BLOCK_WRITE || cmd == CMD_FAST_WRITE;
    wire        link_last = rx_byte && mode_ok && cmd_wait && cmd_write && arg_cnt == 5'h1F;
    wire        self_go   = i_self_req && !busy && !prog_mode;
    wire        commit_go = link_last || self_go;
    wire [7:0]  go_page   = self_go ? i_self_addr.page : ptr.page;
    wire [2:0]  go_block  = self_go ? i_self_addr.block : ptr.block;
    wire        go_absent = !present(go_page, go_block[2]);
    wire        go_prot   = guarded(go_page, i_page_protect);
    wire        commit_at = busy && !busy_erase && busy_cnt == 32'h0000_0001;
    wire        erase_run = busy && busy_erase && !erase_idx[9];

    // same slave behaviour whatever the board context
    always_ff @(posedge i_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            state    <= L_IDLE;
            bit_cnt  <= 4'h0;
            shreg    <= 8'h00;
            o_sda_oe <= 1'b0;
            was_addr <= 1'b0;
            rw       <= 1'b0;
            ack_next <= 1'b0;
            stretch  <= 1'b0;
        end
        else if (start_det)
        begin
            state    <= L_ADDR;
            bit_cnt  <= 4'h0;
            o_sda_oe <= 1'b0;
        end
        else if (stop_det)
        begin
            state    <= L_IDLE;
            o_sda_oe <= 1'b0;
        end
        else
        begin
            if (scl_rise)
            begin
                stretch <= 1'b0;
            end
            if (byte_done)
            begin
                was_addr <= state == L_ADDR;
                rw       <= byte_val[0];
                ack_next <= state == L_ADDR ? addr_ok : data_ok;
            end
            unique case (state)
                L_IDLE:
                begin
                end
                L_ADDR, L_RX:
                begin
                    if (scl_rise)
                    begin
                        shreg   <= byte_val;
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    else if (scl_fall && bit_cnt == 4'h8)
                    begin
                        state    <= L_ACK;
                        o_sda_oe <= ack_next;
                        bit_cnt  <= 4'h0;
                    end
                end
                L_ACK:
                begin
                    if (scl_fall)
                    begin
                        stretch  <= 1'b1;
                        o_sda_oe <= 1'b0;
                        if (!ack_next)
                        begin
                            state <= L_IDLE;
                        end
                        else if (was_addr && rw)
                        begin
                            state    <= L_TX;
                            o_sda_oe <= !tx_byte[7];
                            shreg    <= {tx_byte[6:0], 1'b0};
                            bit_cnt  <= 4'h1;
                        end
                        else
                        begin
                            state <= L_RX;
                        end
                    end
                end
                L_TX:
                begin
                    if (scl_fall && bit_cnt == 4'h8)
                    begin
                        o_sda_oe <= 1'b0;
                        state    <= L_TXACK;
                    end
                    else if (scl_fall)
                    begin
                        o_sda_oe <= !shreg[7];
                        shreg    <= {shreg[6:0], 1'b0};
                        bit_cnt  <= bit_cnt + 4'h1;
                    end
                end
                L_TXACK:
                begin
                    if (scl_rise)
                    begin
                        state <= L_IDLE;
                    end
                end
                default:
                begin
                    state <= L_IDLE;
                end
            endcase
        end
    end

    // command engine: pointer, write buffer, busy timer
    always_ff @(posedge i_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            mode_ok    <= 1'b0;
            cmd_wait   <= 1'b0;
            cmd        <= 8'h00;
            arg_cnt    <= 5'h00;
            ptr        <= '{page: LOCK_PAGE, block: LOCK_BLOCK, offset: LOCK_OFFSET};
            tx_byte    <= 8'h00;
            prot_err   <= 1'b0;
            absent_err <= 1'b0;
            busy       <= 1'b0;
            busy_erase <= 1'b0;
            busy_cnt   <= 32'h0000_0000;
            erase_idx  <= 10'h000;
            cm_page    <= 8'h00;
            cm_block   <= 3'h0;
            cm_fast    <= 1'b0;
            wbuf       <= '0;
        end
        else
        begin
            if (busy)
            begin
                busy_cnt <= busy_cnt - 32'h0000_0001;
                busy     <= busy_cnt != 32'h0000_0001;
            end
            if (erase_run)
            begin
                erase_idx <= erase_idx + 10'h001;
            end
            if (commit_go && go_prot)
            begin
                prot_err <= 1'b1;
            end
            else if (commit_go && go_absent)
            begin
                absent_err <= 1'b1;
            end
            else if (commit_go)
            begin
                busy       <= 1'b1;
                busy_erase <= 1'b0;
                busy_cnt   <= 32'(WRITE_CYCLES);
                cm_page    <= go_page;
                cm_block   <= go_block;
                cm_fast    <= !self_go && cmd == CMD_FAST_WRITE;
            end
            if (self_go)
            begin
                wbuf <= i_self_data;
            end
            if (rx_byte && !mode_ok)
            begin
                mode_ok <= data_ok;
            end
            else if (rx_byte && !cmd_wait)
            begin
                cmd      <= byte_val;
                arg_cnt  <= 5'h00;
                cmd_wait <= byte_val == CMD_SET_PAGE || byte_val == CMD_BLOCK_WRITE
                            || byte_val == CMD_FAST_WRITE;
                unique case (byte_val)
                    CMD_BLOCK_ADVANCE:
                    begin
                        {ptr.page, ptr.block} <= {ptr.page, ptr.block} + 11'h001;
                        ptr.offset            <= 5'h00;
                    end
                    CMD_READ_DATA:
                    begin
                        tx_byte <= locked ? 8'h00 : rd_byte;
                        ptr     <= ptr + 16'h0001;
                    end
                    CMD_READ_STATUS: tx_byte <= status;
                    CMD_GLOBAL_ERASE:
                    begin
                        busy       <= 1'b1;
                        busy_erase <= 1'b1;
                        busy_cnt   <= 32'(ERASE_CYCLES);
                        erase_idx  <= 10'h000;
                        prot_err   <= 1'b0;
                        absent_err <= 1'b0;
                    end
                    default:
                    begin
                    end
                endcase
            end
            else if (rx_byte && cmd == CMD_SET_PAGE)
            begin
                ptr      <= '{page: byte_val, block: 3'h0, offset: 5'h00};
                cmd_wait <= 1'b0;
            end
            else if (rx_byte)
            begin
                wbuf[{arg_cnt, 3'h0} +: 8] <= byte_val;
                arg_cnt  <= arg_cnt + 5'h01;
                cmd_wait <= arg_cnt != 5'h1F;
            end
        end
    end

    // lock set by each committed nonzero lock byte; reset, global erase or a non-fast write of a zero lock byte clears it
    always_ff @(posedge i_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            locked <= 1'b0;
        end
        else if (erase_run)
        begin
            locked <= 1'b0;
        end
        else if (commit_at && cm_page == LOCK_PAGE && cm_block == LOCK_BLOCK)
        begin
            locked <= wbuf[7:0] != 8'h00 || (cm_fast && locked);
        end
    end

    // whole block lands at the end of the timer; erase walks one block a cycle
    always_ff @(posedge i_clk)
    begin
        for (int i = 0; i < BLOCK_BYTES; i++)
        begin
            if (commit_at)
            begin
                mem[{cm_page[5:0], cm_block, 5'(i)}] <= cm_fast
                    ? mem[{cm_page[5:0], cm_block, 5'(i)}] | wbuf[i*8 +: 8]
                    : wbuf[i*8 +: 8];
            end
            if (erase_run)
            begin
                mem[{erase_idx[8:0], 5'(i)}] <= 8'h00;
            end
        end
    end

    // fetch sees every populated bench, flash, RAM, EEPROM or option
    always_ff @(posedge i_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            o_fetch_data <= 8'h00;
        end
        else
        begin
            o_fetch_data <= present(i_fetch_addr.page, i_fetch_addr.block[2])
                ? mem[{i_fetch_addr.page[5:0], i_fetch_addr.block, i_fetch_addr.offset}]
                : 8'h00;
        end
    end

    // clock held low after the ack until the commit or erase is done
    assign o_scl_oe    = busy && stretch;
    assign o_scl_o     = 1'b0;
    assign o_sda_o     = 1'b0;
    assign o_self_busy = busy;
    assign o_prog_mode = prog_mode;
    assign o_locked    = locked;
endmodule

// ==== rtl/nvm_prog_pkg.sv ====
// constants, carriers and states for the paged memory programming block
package nvm_prog_pkg;
    localparam int          PAGE_BYTES      = 256;
    localparam int          BLOCK_BYTES     = 32;
    localparam int          BLOCKS_PER_PAGE = 8;
    localparam int          MEM_PAGES       = 64;
    localparam int          MEM_BLOCKS      = MEM_PAGES * BLOCKS_PER_PAGE;
    localparam int          CLK_PERIOD_NS   = 5;
    localparam int          BLOCK_WRITE_NS  = 2_500_000;
    localparam int          GLOBAL_ERASE_NS = 2_000_000;
    localparam int          BLOCK_WRITE_CYCLES  = BLOCK_WRITE_NS / CLK_PERIOD_NS;
    localparam int          GLOBAL_ERASE_CYCLES = GLOBAL_ERASE_NS / CLK_PERIOD_NS;
    localparam logic [6:0]  SLAVE_ADDR      = 7'h50;
    localparam logic [7:0]  MODE_CODE       = 8'h00;
    localparam logic [7:0]  CMD_BLOCK_WRITE = 8'h01;
    localparam logic [7:0]  CMD_GLOBAL_ERASE = 8'h09;
    localparam logic [7:0]  CMD_FAST_WRITE  = 8'h0B;
    localparam logic [7:0]  CMD_SET_PAGE    = 8'h0C;
    localparam logic [7:0]  CMD_READ_DATA   = 8'h0D;
    localparam logic [7:0]  CMD_BLOCK_ADVANCE = 8'h0F;
    localparam logic [7:0]  CMD_READ_STATUS = 8'h13;
    localparam logic [7:0]  LOCK_PAGE       = 8'h30;
    localparam logic [2:0]  LOCK_BLOCK      = 3'h3;
    localparam logic [4:0]  LOCK_OFFSET     = 5'h00;
    localparam int          STAT_LOCK       = 0;
    localparam int          STAT_PROTECT    = 1;
    localparam int          STAT_ABSENT     = 2;
    localparam int          STAT_BUSY       = 3;

    typedef struct packed {
        logic [7:0] page;
        logic [2:0] block;
        logic [4:0] offset;
    } nvm_addr_type;

    typedef enum logic [2:0] {
        L_IDLE  = 3'b000,
        L_ADDR  = 3'b001,
        L_RX    = 3'b010,
        L_ACK   = 3'b011,
        L_TX    = 3'b100,
        L_TXACK = 3'b101
    } link_state_type;
endpackage

// ==== test/nvm_page_block_programming_tb.sv ====
// bench: programming link, block commits, protect, self write, lock
`timescale 1ns/100ps
module nvm_page_block_programming_tb import nvm_prog_pkg::*;;
    localparam int WC = 100;
    logic         clk, rst_b, vpp, self_req, scl_low, sda_low, ack;
    logic         scl_oe, sda_oe, busy, prog, locked;
    logic [63:0]  prot;
    nvm_addr_type self_addr, fetch_addr;
    logic [255:0] self_data;
    logic [7:0]   fdata, rd;
    wire          scl = !(scl_oe || scl_low);
    wire          sda = !(sda_oe || sda_low);
    int           fails, n_checks, cyc;
    // page 32 as a 128-byte bench
    nvm_page_programmer #(.WRITE_CYCLES(WC), .ERASE_CYCLES(600),
        .HALF_MAP(64'h0000_0001_0000_0000)) dut (
        .i_clk(clk), .i_rst_b(rst_b), .i_vpp_high(vpp), .i_scl(scl), .o_scl_o(),
        .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_o(), .o_sda_oe(sda_oe),
        .i_page_protect(prot), .i_self_req(self_req), .i_self_addr(self_addr),
        .i_self_data(self_data), .o_self_busy(busy), .i_fetch_addr(fetch_addr),
        .o_fetch_data(fdata), .o_prog_mode(prog), .o_locked(locked));
    prog_link_master pm (.i_clk(clk), .i_scl(scl), .i_sda(sda),
        .o_scl_low(scl_low), .o_sda_low(sda_low));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic check(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic tx(input logic [7:0] d, input logic e);
        pm.send(d, ack);
        check(ack === e, "acknowledge");
    endtask
    task automatic fetch(input logic [15:0] a, input logic [7:0] e);
        fetch_addr <= nvm_addr_type'(a);
        w(2);
        check(fdata === e, "fetch data");
    endtask
    task automatic wblk(input logic [7:0] cmd, input logic [7:0] base);
        tx(cmd, 1'b1);
        for (int k = 0; k < BLOCK_BYTES; k++)
            tx(base + 8'(k), 1'b1);
    endtask
    task automatic goto(input logic [7:0] pg, input int blk);
        tx(CMD_SET_PAGE, 1'b1);
        tx(pg, 1'b1);
        repeat (blk) tx(CMD_BLOCK_ADVANCE, 1'b1);
    endtask
    task automatic readback(input logic [7:0] e);
        tx(CMD_READ_DATA, 1'b1);
        pm.stop();
        pm.start();
        tx({SLAVE_ADDR, 1'b1}, 1'b1);
        pm.recv(1'b0, rd);
        check(rd === e, "read data");
        pm.stop();
    endtask
    task automatic reset_to(input logic v);
        rst_b <= 1'b0;
        vpp   <= v;
        w(2);
        rst_b <= 1'b1;
        w(10);
        check(prog === v, "mode strap");
    endtask
    task automatic enter;
        reset_to(1'b1);
        pm.start();
        tx({SLAVE_ADDR, 1'b0}, 1'b1);
        tx(MODE_CODE, 1'b1);
    endtask
    task automatic t_blocks;
        enter();
        goto(8'h00, 7);
        wblk(CMD_BLOCK_WRITE, 8'h40);
        w(2);
        check(scl_oe === 1'b1 && busy === 1'b1, "commit not stretching");
        tx(CMD_BLOCK_ADVANCE, 1'b1);
        wblk(CMD_BLOCK_WRITE, 8'h80);
        prot[1] <= 1'b1;
        goto(8'h01, 0);
        wblk(CMD_FAST_WRITE, 8'h13);
        for (int k = 0; k < BLOCK_BYTES; k++)
        begin
            fetch(16'h00E0 + 16'(k), 8'h40 + 8'(k));
            fetch(16'h0100 + 16'(k), 8'h80 + 8'(k));
        end
        fetch(16'h4000, 8'h00);
        fetch(16'h2000, 8'h00);
        goto(8'h00, 7);
        readback(8'h40);
        $display("test blocks done");
    endtask
    task automatic t_self;
        logic [255:0] d;
        reset_to(1'b0);
        pm.start();
        tx({SLAVE_ADDR, 1'b0}, 1'b0);
        pm.stop();
        for (int k = 0; k < BLOCK_BYTES; k++)
            d[8*k +: 8] = 8'hC0 + 8'(k);
        self_addr <= nvm_addr_type'(16'h1000);
        self_data <= d;
        self_req  <= 1'b1;
        w(1);
        self_req <= 1'b0;
        w(1);
        check(busy === 1'b1, "self busy");
        w(WC - 2);
        check(busy === 1'b1, "busy short");
        w(2);
        check(busy === 1'b0, "busy long");
        for (int k = 0; k < BLOCK_BYTES; k++)
            fetch(16'h1000 + 16'(k), 8'hC0 + 8'(k));
        $display("test self done");
    endtask
    task automatic t_lock;
        enter();
        wblk(CMD_BLOCK_WRITE, 8'h5A);
        readback(8'h00);
        check(locked === 1'b1, "lock");
        fetch(16'h3060, 8'h5A);
        fetch(16'h3061, 8'h5B);
        $display("test lock done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            fails++;
            wrap_up();
        end
    end
    initial
    begin
        rst_b = 1'b0;
        vpp = 1'b1;
        self_req = 1'b0;
        prot = '0;
        self_addr = '0;
        fetch_addr = '0;
        self_data = '0;
        fails = 0;
        n_checks = 0;
        cyc = 0;
        t_blocks();
        t_self();
        t_lock();
        wrap_up();
    end
endmodule

// ==== test/nvm_prog_assertions.sv ====
// port checks for the paged memory programming block
`timescale 1ns/100ps
module nvm_prog_assertions import nvm_prog_pkg::*; #(
    parameter int WRITE_CYCLES = 20,
    parameter int ERASE_CYCLES = 600
)(
    input wire logic         i_clk,
    input wire logic         i_rst_b,
    input wire logic         i_vpp_high,
    input wire logic         i_scl,
    input wire logic         i_self_req,
    input wire nvm_addr_type i_fetch_addr,
    input wire logic         o_scl_oe,
    input wire logic         o_sda_oe,
    input wire logic         o_self_busy,
    input wire logic [7:0]   o_fetch_data,
    input wire logic         o_prog_mode
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    int busy_cnt;
    always_ff @(posedge i_clk or negedge i_rst_b)
        if (!i_rst_b)
            busy_cnt <= 0;
        else
            busy_cnt <= o_self_busy ? busy_cnt + 1 : 0;
    chk_quiet_run: assert property
        (!o_prog_mode |-> !o_sda_oe && !o_scl_oe) else $error("link driven outside mode");
    chk_mode_rise: assert property
        ($rose(o_prog_mode) |-> i_vpp_high) else $error("mode entered without vpp");
    chk_mode_keep: assert property
        (!$fell(o_prog_mode)) else $error("mode lost without reset");
    chk_sda_scl_low: assert property
        ($changed(o_sda_oe) |-> !i_scl) else $error("data changed while clock high");
    chk_stretch_busy: assert property
        (o_scl_oe |-> o_self_busy) else $error("clock held without commit");
    chk_commit_len: assert property
        ($fell(o_self_busy) |-> busy_cnt == WRITE_CYCLES || busy_cnt == ERASE_CYCLES)
        else $error("commit length wrong");
    chk_self_take: assert property
        (i_self_req && !o_self_busy && !o_prog_mode |=> o_self_busy)
        else $error("self write not taken");
    chk_absent_zero: assert property
        (i_fetch_addr.page[7:6] != 2'b00 |=> o_fetch_data == 8'h00)
        else $error("absent page returned data");
    cover property (o_scl_oe);
    cover property ($rose(o_self_busy) && !o_prog_mode);
    cover property ($rose(o_sda_oe));
endmodule
bind nvm_page_programmer nvm_prog_assertions #(
    .WRITE_CYCLES(WRITE_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)
) u_chk (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_vpp_high(i_vpp_high), .i_scl(i_scl),
    .i_self_req(i_self_req), .i_fetch_addr(i_fetch_addr), .o_scl_oe(o_scl_oe),
    .o_sda_oe(o_sda_oe), .o_self_busy(o_self_busy), .o_fetch_data(o_fetch_data),
    .o_prog_mode(o_prog_mode)
);

// ==== test/prog_link_master.sv ====
// two-wire programmer model on open-drain clock and data
`timescale 1ns/100ps
module prog_link_master (
    input  wire logic i_clk,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_scl_low,
    output logic      o_sda_low
);
    initial
    begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // release clock; device may hold it low through a commit
    task automatic rel;
        int n;
        o_scl_low <= 1'b0;
        n = 0;
        while (i_scl !== 1'b1 && n < 4000)
        begin
            w(1);
            n++;
        end
    endtask
    // at least 33 cycles a bit; data moves 4 cycles after clock falls for hold
    task automatic bit_io(input logic b, output logic r);
        o_sda_low <= !b;
        w(12);
        rel();
        w(16);
        r = i_sda;
        o_scl_low <= 1'b1;
        w(4);
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic recv(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(!ack, r);
    endtask
    task automatic start;
        o_sda_low <= 1'b1;
        w(16);
        o_scl_low <= 1'b1;
        w(4);
    endtask
    task automatic stop;
        o_sda_low <= 1'b1;
        w(12);
        rel();
        w(16);
        o_sda_low <= 1'b0;
        w(16);
    endtask
endmodule
